// File: core/sfb_core.sv
//
// Contract
// - Four banks of eight 8-bit working registers, each reachable alone.
// - One bank active, picked by two bank-select bits of the status word.
// - First two registers of active bank serve as indirect pointers.
// - Special registers live at 80h-FFh, direct only, never indirect.
// - Bit access only to special registers at addresses ending 0 or 8.
// - Unimplemented special register addresses or bits read as ones.
// - Software-reset plus enable-key bits both one resets like power-on.
// - Programming-select plus enable-key bits both one enter programming.
// - Trigger-type bit one means falling edge, zero means low level.
// - Edge mode sets pending flag on edge, clears it when serviced.
// - Each interrupt requested only while its enable bit is one.
// - Priority bit one gives that interrupt the high priority level.
// - Flash address low register supplies flash address bits 7 to 0.
//
`timescale 1ns/1ps

module sfb_core (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [1:0] i_mode,
  input wire logic i_write,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_ext_int2_n,
  input wire logic i_ext_int3_n,
  input wire logic i_irq2_ack,
  input wire logic i_irq3_ack,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic [1:0] o_bank_select,
  output logic o_irq2_req,
  output logic o_irq3_req,
  output logic o_irq2_high_prio,
  output logic o_irq3_high_prio,
  output logic o_soft_reset,
  output logic o_isp_mode,
  output logic [7:0] o_flash_addr_low
);

  typedef struct packed {
    logic [7:0] acc_addr, wdata_q, rdata;
    logic acc_ram, acc_write, acc_bit, done, ready, soft_rst, in_system_program_select;
    logic [2:0] bit_pos;
    logic [7:0] t0_low, t1_low, t0_high, t1_high;
    logic [7:0] flash_low, status_word, irq_ctl, chip_ctl;
    logic [1:0] irq_req, irq_prio;
  } sfb_regs_type;

  // Power-on and software reset share one image so they cannot drift apart
  localparam sfb_regs_type REGS_RESET = '{ready: 1'b1, default: '0};

  sfb_pkg::sfb_state_type state, next_state;
  sfb_regs_type regs, next_regs;

  logic [7:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] sfr_rd;
  logic sfr_hit;
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic [1:0] bank;

  logic [1:0] int_meta, int_sync, int_prev;
  logic [1:0] irq_edge;
  logic [1:0] irq_ack;

  assign bank =
    regs.status_word[sfb_pkg::STATUS_BANK_HI:sfb_pkg::STATUS_BANK_LO];
  assign irq_ack = {i_irq3_ack, i_irq2_ack};

  sfb_ram u_ram (
    .i_clock(i_clock),
    .i_addr(mem_addr),
    .i_write(mem_we),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // Pins come from outside; the first stage is read only by the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      int_meta <= 2'h3;
      int_sync <= 2'h3;
      int_prev <= 2'h3;
    end else begin
      int_meta <= {i_ext_int3_n, i_ext_int2_n};
      int_sync <= int_meta;
      int_prev <= int_sync;
    end
  end

  assign irq_edge = int_prev & ~int_sync;

  // Special register read mux; anything not listed reads all ones
  always_comb begin
    sfr_hit = 1'b1;
    case (regs.acc_addr)
      sfb_pkg::ADDR_TIMER0_LOW: sfr_rd = regs.t0_low;
      sfb_pkg::ADDR_TIMER1_LOW: sfr_rd = regs.t1_low;
      sfb_pkg::ADDR_TIMER0_HIGH: sfr_rd = regs.t0_high;
      sfb_pkg::ADDR_TIMER1_HIGH: sfr_rd = regs.t1_high;
      sfb_pkg::ADDR_CHIP_CTL:
        sfr_rd = regs.chip_ctl | ~sfb_pkg::CHIP_USED_MASK;
      sfb_pkg::ADDR_EXT_IRQ23: sfr_rd = regs.irq_ctl;
      sfb_pkg::ADDR_FLASH_LOW: sfr_rd = regs.flash_low;
      sfb_pkg::ADDR_STATUS: sfr_rd = regs.status_word;
      default: begin
        sfr_rd = sfb_pkg::READ_ONES;
        sfr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_regs = regs;
    next_regs.done = 1'b0;
    next_regs.soft_rst = 1'b0;
    mem_addr = regs.acc_addr;
    mem_we = 1'b0;
    mem_wdata = regs.wdata_q;
    old_byte = regs.acc_ram ? mem_rdata : sfr_rd;
    new_byte = old_byte;
    new_byte[regs.bit_pos] = regs.wdata_q[0];
    if (!regs.acc_bit) begin
      new_byte = regs.wdata_q;
    end
    case (state)
      sfb_pkg::ST_IDLE: begin
        if (regs.ready && i_req) begin
          next_regs.acc_write = i_write;
          next_regs.wdata_q = i_wdata;
          next_regs.acc_bit = 1'b0;
          next_regs.bit_pos = i_addr[2:0];
          next_state = sfb_pkg::ST_ACC;
          case (sfb_pkg::sfb_mode_type'(i_mode))
            sfb_pkg::MODE_DIRECT: begin
              next_regs.acc_addr = i_addr;
              next_regs.acc_ram = i_addr < sfb_pkg::SFR_BASE;
            end
            sfb_pkg::MODE_WREG: begin
              next_regs.acc_addr = {3'h0, bank, i_addr[2:0]};
              next_regs.acc_ram = 1'b1;
            end
            sfb_pkg::MODE_INDIRECT: begin
              mem_addr = {3'h0, bank, 2'h0, i_addr[0]};
              next_state = sfb_pkg::ST_PTR;
            end
            default: begin
              // Bit space: low half maps onto RAM 20h-2Fh, upper half onto
              // special registers whose address ends in 0 or 8
              next_regs.acc_bit = 1'b1;
              next_regs.acc_ram = !i_addr[7];
              next_regs.acc_addr = i_addr[7] ? {i_addr[7:3], 3'h0}
                : (sfb_pkg::BIT_RAM_BASE | {4'h0, i_addr[6:3]});
            end
          endcase
        end
      end
      sfb_pkg::ST_PTR: begin
        // Pointer may hold any value; indirect always lands in RAM
        next_regs.acc_addr = mem_rdata;
        next_regs.acc_ram = 1'b1;
        next_state = sfb_pkg::ST_ACC;
      end
      sfb_pkg::ST_ACC: begin
        next_state = sfb_pkg::ST_FIN;
      end
      sfb_pkg::ST_FIN: begin
        next_regs.done = 1'b1;
        next_state = sfb_pkg::ST_IDLE;
        if (!regs.acc_write) begin
          next_regs.rdata = regs.acc_bit
            ? {7'h00, old_byte[regs.bit_pos]} : old_byte;
        end else if (regs.acc_ram) begin
          mem_we = 1'b1;
          mem_wdata = new_byte;
        end else begin
          case (regs.acc_addr)
            sfb_pkg::ADDR_TIMER0_LOW: next_regs.t0_low = new_byte;
            sfb_pkg::ADDR_TIMER1_LOW: next_regs.t1_low = new_byte;
            sfb_pkg::ADDR_TIMER0_HIGH: next_regs.t0_high = new_byte;
            sfb_pkg::ADDR_TIMER1_HIGH: next_regs.t1_high = new_byte;
            sfb_pkg::ADDR_FLASH_LOW: next_regs.flash_low = new_byte;
            sfb_pkg::ADDR_STATUS: next_regs.status_word = new_byte;
            sfb_pkg::ADDR_EXT_IRQ23: next_regs.irq_ctl = new_byte;
            sfb_pkg::ADDR_CHIP_CTL: begin
              next_regs.chip_ctl = new_byte & sfb_pkg::CHIP_USED_MASK;
              // Both key and reset bits are needed; either alone is inert
              next_regs.soft_rst = new_byte[sfb_pkg::CHIP_RESET]
                && new_byte[sfb_pkg::CHIP_KEY];
            end
            default: begin
            end
          endcase
        end
      end
      default: next_state = sfb_pkg::ST_IDLE;
    endcase

    // Hardware flag updates come after the software write so a set wins
    for (int k = 0; k < sfb_pkg::IRQ_COUNT; k++) begin
      if (regs.irq_ctl[sfb_pkg::XI_TRIGGER + k * sfb_pkg::XI_STRIDE]) begin
        if (irq_ack[k]) begin
          next_regs.irq_ctl[sfb_pkg::XI_PENDING
            + k * sfb_pkg::XI_STRIDE] = 1'b0;
        end
        if (irq_edge[k]) begin
          next_regs.irq_ctl[sfb_pkg::XI_PENDING
            + k * sfb_pkg::XI_STRIDE] = 1'b1;
        end
      end else begin
        // Level mode: flag simply follows the synchronised low level
        next_regs.irq_ctl[sfb_pkg::XI_PENDING
          + k * sfb_pkg::XI_STRIDE] = ~int_sync[k];
      end
      next_regs.irq_req[k] = next_regs.irq_ctl[sfb_pkg::XI_ENABLE
        + k * sfb_pkg::XI_STRIDE] && next_regs.irq_ctl[sfb_pkg::XI_PENDING
        + k * sfb_pkg::XI_STRIDE];
      next_regs.irq_prio[k] = next_regs.irq_ctl[sfb_pkg::XI_PRIORITY
        + k * sfb_pkg::XI_STRIDE];
    end

    // Software reset: the cycle after the pulse looks exactly like power-on
    if (regs.soft_rst) begin
      next_state = sfb_pkg::ST_IDLE;
      next_regs = REGS_RESET;
    end
    // No request is taken while a software reset is pending
    next_regs.ready = (next_state == sfb_pkg::ST_IDLE)
      && !next_regs.soft_rst;
    next_regs.in_system_program_select = next_regs.chip_ctl[sfb_pkg::CHIP_ISP]
      && next_regs.chip_ctl[sfb_pkg::CHIP_KEY];
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= sfb_pkg::ST_IDLE;
      regs <= REGS_RESET;
    end else begin
      state <= next_state;
      regs <= next_regs;
    end
  end

  assign o_ready = regs.ready;
  assign o_done = regs.done;
  assign o_rdata = regs.rdata;
  assign o_bank_select = bank;
  assign o_irq2_req = regs.irq_req[0];
  assign o_irq3_req = regs.irq_req[1];
  assign o_irq2_high_prio = regs.irq_prio[0];
  assign o_irq3_high_prio = regs.irq_prio[1];
  assign o_soft_reset = regs.soft_rst;
  assign o_isp_mode = regs.in_system_program_select;
  assign o_flash_addr_low = regs.flash_low;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  direct_latency_a: assert property (
    regs.ready && i_req && i_mode != 2'h1
      |=> ##1 state == sfb_pkg::ST_FIN ##1 regs.done
  ) else $error("direct access did not finish in three cycles");

  indirect_latency_a: assert property (
    regs.ready && i_req && i_mode == 2'h1
      |=> state == sfb_pkg::ST_PTR ##2 state == sfb_pkg::ST_FIN ##1 regs.done
  ) else $error("indirect access did not finish in four cycles");

  indirect_ram_a: assert property (
    state == sfb_pkg::ST_PTR && !regs.soft_rst |=> regs.acc_ram
  ) else $error("indirect access reached a special register");

  bank_write_a: assert property (
    state == sfb_pkg::ST_FIN && regs.acc_write && !regs.acc_ram
      && !regs.acc_bit && regs.acc_addr == sfb_pkg::ADDR_STATUS
      |=> o_bank_select == $past(regs.wdata_q[4:3])
  ) else $error("bank select did not follow status word write");

  bit_keep_a: assert property (
    mem_we && regs.acc_bit
      |-> ((mem_wdata ^ mem_rdata) & ~(8'h01 << regs.bit_pos)) == 8'h00
  ) else $error("bit write disturbed other bits");

  unmapped_ones_a: assert property (
    state == sfb_pkg::ST_FIN && !regs.acc_write && !regs.acc_ram
      && !regs.acc_bit && !sfr_hit |=> o_rdata == 8'hFF
  ) else $error("unimplemented register did not read ones");

  soft_reset_a: assert property (
    state == sfb_pkg::ST_FIN && regs.acc_write && !regs.acc_ram
      && !regs.acc_bit && regs.acc_addr == sfb_pkg::ADDR_CHIP_CTL
      |=> o_soft_reset == ($past(regs.wdata_q[7]) && $past(regs.wdata_q[0]))
      && !(o_soft_reset && o_ready)
      ##1 (!$past(o_soft_reset) || (o_ready && o_flash_addr_low == 8'h00))
  ) else $error("software reset key decode wrong");

  isp_entry_a: assert property (
    $rose(o_isp_mode) |-> $past(state) == sfb_pkg::ST_FIN
      && $past(regs.acc_addr) == sfb_pkg::ADDR_CHIP_CTL
  ) else $error("programming mode entered without control write");

  edge_pending_a: assert property (
    regs.irq_ctl[0] && irq_edge[0] && !regs.soft_rst
      |=> regs.irq_ctl[1] && o_irq2_req == regs.irq_ctl[2]
  ) else $error("falling edge did not set irq2 pending");

  flash_low_a: assert property (
    state == sfb_pkg::ST_FIN && regs.acc_write && !regs.acc_ram
      && !regs.acc_bit && regs.acc_addr == sfb_pkg::ADDR_FLASH_LOW
      |=> o_flash_addr_low == $past(regs.wdata_q)
  ) else $error("flash address low not updated");

endmodule : sfb_core

// File: core/sfb_pkg.sv
package sfb_pkg;

  // Address map of the direct space
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CHIP_CTL = 8'hBF;
  localparam logic [7:0] ADDR_EXT_IRQ23 = 8'hC0;
  localparam logic [7:0] ADDR_FLASH_LOW = 8'hC4;
  localparam logic [7:0] ADDR_STATUS = 8'hD0;

  localparam logic [7:0] READ_ONES = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Program status word fields
  localparam int unsigned STATUS_BANK_LO = 3;
  localparam int unsigned STATUS_BANK_HI = 4;

  // Chip reset and programming control fields
  localparam int unsigned CHIP_RESET = 7;
  localparam int unsigned CHIP_ISP = 1;
  localparam int unsigned CHIP_KEY = 0;
  localparam logic [7:0] CHIP_USED_MASK = 8'h83;

  // External interrupt 2/3 control fields; irq3 sits one stride above irq2
  localparam int unsigned XI_TRIGGER = 0;
  localparam int unsigned XI_PENDING = 1;
  localparam int unsigned XI_ENABLE = 2;
  localparam int unsigned XI_PRIORITY = 3;
  localparam int unsigned XI_STRIDE = 4;
  localparam int unsigned IRQ_COUNT = 2;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_INDIRECT = 2'b01,
    MODE_WREG = 2'b10,
    MODE_BIT = 2'b11
  } sfb_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PTR = 2'b01,
    ST_ACC = 2'b10,
    ST_FIN = 2'b11
  } sfb_state_type;

endpackage : sfb_pkg

// File: core/sfb_ram.sv
`timescale 1ns/1ps

module sfb_ram (
  input wire logic i_clock,
  input wire logic [7:0] i_addr,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [0:255];

  // Read is registered; a write returns the old byte in the same edge
  always_ff @(posedge i_clock) begin
    if (i_write) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule : sfb_ram

// File: testbench/sfb_cpu_model.sv
`timescale 1ns/1ps

module sfb_cpu_model (
  input wire logic i_clock,
  input wire logic i_ready,
  input wire logic i_done,
  output logic o_req,
  output logic [1:0] o_mode,
  output logic o_write,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_irq2_ack,
  output logic o_irq3_ack
);
  initial begin
    o_req = 1'b0;
    o_mode = 2'b00;
    o_write = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_irq2_ack = 1'b0;
    o_irq3_ack = 1'b0;
  end

  // One access at a time; ok stays low if never taken or never finished
  task automatic access(input logic [1:0] m, input logic w,
                        input logic [7:0] a, input logic [7:0] d,
                        output logic ok);
    int n;
    logic fin;
    ok = 1'b0;
    fin = 1'b0;
    @(negedge i_clock);
    o_req = 1'b1;
    o_mode = m;
    o_write = w;
    o_addr = a;
    o_wdata = d;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge i_clock);
      ok = i_ready;
    end
    @(negedge i_clock);
    o_req = 1'b0;
    // Released address and data lines are inverted so a stale value can never pass
    o_addr = ~a;
    o_wdata = ~d;
    for (n = 0; n < 8 && ok && !fin; n++) begin
      @(posedge i_clock);
      fin = i_done;
    end
    ok = fin;
  endtask : access

  task automatic ack(input logic three);
    @(negedge i_clock);
    o_irq2_ack = !three;
    o_irq3_ack = three;
    @(negedge i_clock);
    o_irq2_ack = 1'b0;
    o_irq3_ack = 1'b0;
  endtask : ack
endmodule : sfb_cpu_model

// File: testbench/sfr_space_and_bank_control_tb.sv
`timescale 1ns/1ps

module sfr_space_and_bank_control_tb;
  logic i_clock;
  logic i_rst;
  logic int2_n, int3_n, req, wr, ack2, ack3, ready, done;
  logic irq2, irq3, pr2, pr3, srst, in_system_program_select, rd_pend;
  logic [1:0] mode, bank;
  logic [7:0] addr, wdata, rdata, flash;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  logic [7:0] vals[5];
  logic [7:0] regs[5] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC4};
  logic [7:0] one_bit[3] = '{8'h80, 8'h02, 8'h01};
  int error_cnt, compares, srst_cnt, seed, n;

  sfb_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_req(req),
    .i_mode(mode), .i_write(wr), .i_addr(addr), .i_wdata(wdata),
    .i_ext_int2_n(int2_n), .i_ext_int3_n(int3_n), .i_irq2_ack(ack2),
    .i_irq3_ack(ack3), .o_ready(ready), .o_done(done), .o_rdata(rdata),
    .o_bank_select(bank), .o_irq2_req(irq2), .o_irq3_req(irq3),
    .o_irq2_high_prio(pr2), .o_irq3_high_prio(pr3), .o_soft_reset(srst),
    .o_isp_mode(in_system_program_select), .o_flash_addr_low(flash));

  sfb_cpu_model cpu (.i_clock(i_clock), .i_ready(ready), .i_done(done),
    .o_req(req), .o_mode(mode), .o_write(wr), .o_addr(addr),
    .o_wdata(wdata), .o_irq2_ack(ack2), .o_irq3_ack(ack3));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Reads are judged when their done pulse shows, oldest note first
  always @(posedge i_clock) begin
    if (done && rd_pend) begin
      rd_pend = 1'b0;
      chk(rdata, exp_q.pop_front());
    end
    if (ready && req) rd_pend = !wr;
    if (srst) srst_cnt++;
  end

  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic acc(input logic [1:0] m, input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    logic ok;
    cpu.access(m, w, a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
      close_out();
    end
  endtask : acc

  task automatic rd(input logic [1:0] m, input logic [7:0] a,
                    input logic [7:0] e);
    exp_q.push_back(e);
    acc(m, 1'b0, a, 8'h00);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(negedge i_clock);
  endtask : idle

  initial begin
    seed = 90;
    error_cnt = 0;
    compares = 0;
    srst_cnt = 0;
    rd_pend = 1'b0;
    int2_n = 1'b1;
    int3_n = 1'b1;
    i_rst = 1'b1;
    idle(3);
    i_rst = 1'b0;
    foreach (regs[i]) rd(2'b00, regs[i], 8'h00);
    rd(2'b00, sfb_pkg::ADDR_STATUS, 8'h00);
    rd(2'b00, sfb_pkg::ADDR_CHIP_CTL, 8'h7C);
    acc(2'b00, 1'b1, 8'h84, 8'h12);
    rd(2'b00, 8'h84, 8'hFF);
    $display("reset and unmapped test done");
    for (int i = 0; i < 5; i++) begin
      vals[i] = 8'($random(seed));
      acc(2'b00, 1'b1, regs[i], vals[i]);
      rd(2'b00, regs[i], vals[i]);
    end
    idle(1);
    chk(flash, vals[4]);
    $display("timer and flash test done");
    for (int b = 0; b < 8; b++) begin
      acc(2'b00, 1'b1, sfb_pkg::ADDR_STATUS, 8'((b % 4) << 3));
      idle(1);
      chk({6'h00, bank}, 8'(b % 4));
      for (int r = 0; r < 8; r++) begin
        v = 8'((b % 4) * 16 + r);
        if (b < 4) acc(2'b10, 1'b1, 8'(r), v);
        else rd(2'b10, 8'(r), v);
        if (b >= 4) rd(2'b00, 8'((b % 4) * 8 + r), v);
      end
    end
    $display("bank test done");
    acc(2'b10, 1'b1, 8'h00, 8'h40);
    acc(2'b10, 1'b1, 8'h01, sfb_pkg::ADDR_TIMER0_LOW);
    acc(2'b01, 1'b1, 8'h00, 8'h5A);
    rd(2'b00, 8'h40, 8'h5A);
    acc(2'b01, 1'b1, 8'h01, 8'hC3);
    rd(2'b01, 8'h01, 8'hC3);
    rd(2'b00, sfb_pkg::ADDR_TIMER0_LOW, vals[0]);
    $display("indirect test done");
    acc(2'b00, 1'b1, 8'h20, 8'h00);
    acc(2'b11, 1'b1, 8'h05, 8'h01);
    rd(2'b00, 8'h20, 8'h20);
    rd(2'b11, 8'h05, 8'h01);
    acc(2'b11, 1'b1, 8'h8A, 8'h01);
    rd(2'b00, sfb_pkg::ADDR_TIMER0_LOW, vals[0]);
    acc(2'b11, 1'b1, 8'hC2, 8'h01);
    rd(2'b00, sfb_pkg::ADDR_EXT_IRQ23, 8'h04);
    $display("bit test done");
    acc(2'b00, 1'b1, sfb_pkg::ADDR_EXT_IRQ23, 8'h0D);
    idle(1);
    chk({6'h00, pr3, pr2}, 8'h01);
    int2_n = 1'b0;
    idle(6);
    chk({7'h00, irq2}, 8'h01);
    rd(2'b00, sfb_pkg::ADDR_EXT_IRQ23, 8'h0F);
    int2_n = 1'b1;
    idle(6);
    chk({7'h00, irq2}, 8'h01);
    cpu.ack(1'b0);
    idle(2);
    chk({7'h00, irq2}, 8'h00);
    acc(2'b00, 1'b1, sfb_pkg::ADDR_EXT_IRQ23, 8'h80);
    idle(1);
    chk({6'h00, pr3, pr2}, 8'h02);
    int3_n = 1'b0;
    idle(6);
    chk({7'h00, irq3}, 8'h00);
    rd(2'b00, sfb_pkg::ADDR_EXT_IRQ23, 8'hA0);
    acc(2'b00, 1'b1, sfb_pkg::ADDR_EXT_IRQ23, 8'hC0);
    idle(2);
    chk({7'h00, irq3}, 8'h01);
    int3_n = 1'b1;
    idle(6);
    chk({7'h00, irq3}, 8'h00);
    $display("interrupt test done");
    foreach (one_bit[i]) begin
      acc(2'b00, 1'b1, sfb_pkg::ADDR_CHIP_CTL, one_bit[i]);
      rd(2'b00, sfb_pkg::ADDR_CHIP_CTL, one_bit[i] | 8'h7C);
      chk({7'h00, in_system_program_select}, 8'h00);
    end
    chk(8'(srst_cnt), 8'h00);
    acc(2'b00, 1'b1, sfb_pkg::ADDR_CHIP_CTL, 8'h03);
    idle(1);
    chk({7'h00, in_system_program_select}, 8'h01);
    acc(2'b00, 1'b1, sfb_pkg::ADDR_CHIP_CTL, 8'h81);
    for (n = 0; n < 10 && srst_cnt == 0; n++) idle(1);
    idle(2);
    chk(8'(srst_cnt), 8'h01);
    chk({5'h00, in_system_program_select, bank}, 8'h00);
    rd(2'b00, sfb_pkg::ADDR_TIMER0_LOW, 8'h00);
    rd(2'b00, sfb_pkg::ADDR_CHIP_CTL, 8'h7C);
    rd(2'b00, 8'h40, 8'h5A);
    $display("chip control test done");
    idle(2);
    close_out();
  end
endmodule : sfr_space_and_bank_control_tb
